// ---- verilog/oamu_pkg.sv ----
// Purpose: Shared constants and types for the operand address mode unit.
// Assumes: 16-bit machine words, APB register access with 32-bit data.
// Notes: Register offsets are byte addresses on the APB port.
package oamu_pkg;

  localparam int unsigned OAMU_DW = 16;
  localparam int unsigned OAMU_NREG = 8;

  localparam logic [7:0] OAMU_OFS_CTRL = 8'h00;
  localparam logic [7:0] OAMU_OFS_STATUS = 8'h04;
  localparam logic [7:0] OAMU_OFS_EADDR = 8'h08;
  localparam logic [7:0] OAMU_OFS_OPERAND = 8'h0C;
  localparam logic [7:0] OAMU_OFS_PSW = 8'h10;
  localparam logic [7:0] OAMU_OFS_FLAGOP = 8'h14;
  localparam logic [7:0] OAMU_OFS_BRANCH = 8'h18;
  localparam logic [7:0] OAMU_OFS_ALU_A = 8'h1C;
  localparam logic [7:0] OAMU_OFS_ALU = 8'h20;
  localparam logic [2:0] OAMU_GPR_PAGE = 3'h2;

  localparam int OAMU_CTRL_BYTE_BIT = 6;
  localparam int OAMU_CTRL_START_BIT = 8;
  localparam int OAMU_STATUS_BUSY_BIT = 0;
  localparam int OAMU_STATUS_DONE_BIT = 1;
  localparam int OAMU_FLAGOP_SET_BIT = 4;
  localparam int OAMU_BRANCH_COND_LSB = 8;
  localparam int OAMU_BRANCH_TAKEN_BIT = 16;
  localparam int OAMU_ALU_SUB_BIT = 16;

  localparam logic [2:0] OAMU_SP_IDX = 3'h6;
  localparam logic [2:0] OAMU_PC_IDX = 3'h7;
  localparam logic [15:0] OAMU_STEP_WORD = 16'h0002;
  localparam logic [15:0] OAMU_STEP_BYTE = 16'h0001;
  localparam logic [15:0] OAMU_GPR_RESET = 16'h0000;
  localparam logic [3:0] OAMU_PSW_RESET = 4'h0;

  typedef enum logic [2:0] {
    mode_register = 3'b000,
    mode_reg_deferred = 3'b001,
    mode_autoinc = 3'b010,
    mode_autoinc_deferred = 3'b011,
    mode_autodec = 3'b100,
    mode_autodec_deferred = 3'b101,
    mode_index = 3'b110,
    mode_index_deferred = 3'b111
  } oamu_mode_t;

  typedef struct packed {
    oamu_mode_t mode;
    logic [2:0] rn;
  } oamu_field_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } oamu_flags_t;

  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } oamu_mem_req_t;

  typedef enum logic [4:0] {
    branch_always = 5'b00000,
    branch_on_not_equal = 5'b00001,
    branch_on_equal = 5'b00010,
    branch_on_greater_equal = 5'b00011,
    branch_on_less = 5'b00100,
    branch_on_greater = 5'b00101,
    branch_on_less_equal = 5'b00110,
    branch_on_plus = 5'b00111,
    branch_on_minus = 5'b01000,
    branch_on_higher = 5'b01001,
    branch_on_lower_same = 5'b01010,
    branch_on_overflow_clear = 5'b01011,
    branch_on_overflow_set = 5'b01100,
    branch_on_carry_clear = 5'b01101,
    branch_on_carry_set = 5'b01110,
    branch_on_higher_same = 5'b01111,
    branch_on_lower = 5'b10000
  } oamu_cond_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_xfetch = 2'b01,
    st_ptr = 2'b10
  } oamu_state_t;

endpackage

// ---- verilog/oamu_core.sv ----
// Purpose: Operand address formation, condition flags and branch evaluation.
// Assumes: One 10 MHz clock, synchronous active-low reset, memory port on the same clock.
// Notes: APB slave with zero wait states; read data is captured in the setup cycle.
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps

module oamu_core
  import oamu_pkg::*;
#(
  parameter int APB_AW = 8
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output oamu_mem_req_t mem_req_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  output logic busy_o,
  output oamu_flags_t flags_o
);

  if (APB_AW < 8)
  begin : g_aw_check
    $error("APB_AW must be at least 8 bits.");
  end

  logic [15:0] gpr_r [OAMU_NREG];
  oamu_flags_t psw_r;
  oamu_state_t state_r;
  oamu_field_t field_r;
  oamu_mem_req_t mem_r;
  logic byte_r;
  logic done_r;
  logic taken_r;
  logic [15:0] ea_r;
  logic [15:0] opnd_r;
  logic [15:0] alu_a_r;
  logic [15:0] alu_res_r;
  logic [31:0] prdata_r;

  logic [7:0] addr_lo;
  logic addr_hi_zero;
  logic gpr_sel;
  logic [2:0] gpr_idx;
  logic addr_ok;
  logic apb_wr;
  logic apb_setup;
  logic start_req;
  oamu_field_t start_field;
  logic start_byte;
  logic [15:0] start_reg;
  logic [15:0] start_step;
  logic [15:0] dec_val;
  logic [15:0] pc_next;
  logic [15:0] idx_sum;
  logic [16:0] alu_sum;
  logic [15:0] alu_b;
  logic alu_sub;
  logic [7:0] br_off;
  oamu_cond_t br_cond;
  logic [15:0] br_target;

  // Auto-increment and auto-decrement step; the two pointer registers never step by one.
  function automatic logic [15:0] step_of(input logic is_byte, input logic [2:0] rn);
    logic [15:0] s;
    s = OAMU_STEP_WORD;
    if (is_byte && rn != OAMU_SP_IDX && rn != OAMU_PC_IDX)
    begin
      s = OAMU_STEP_BYTE;
    end
    return s;
  endfunction

  function automatic logic cond_true(input oamu_cond_t cnd, input oamu_flags_t f);
    logic t;
    t = 1'b0;
    case (cnd)
      branch_always: t = 1'b1;
      branch_on_not_equal: t = !f.z;
      branch_on_equal: t = f.z;
      branch_on_greater_equal: t = !(f.n ^ f.v);
      branch_on_less: t = f.n ^ f.v;
      branch_on_greater: t = !(f.z | (f.n ^ f.v));
      branch_on_less_equal: t = f.z | (f.n ^ f.v);
      branch_on_plus: t = !f.n;
      branch_on_minus: t = f.n;
      branch_on_higher: t = !(f.c | f.z);
      branch_on_lower_same: t = f.c | f.z;
      branch_on_overflow_clear: t = !f.v;
      branch_on_overflow_set: t = f.v;
      branch_on_carry_clear: t = !f.c;
      branch_on_carry_set: t = f.c;
      branch_on_higher_same: t = !f.c;
      branch_on_lower: t = f.c;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  assign addr_lo = paddr_i[7:0];
  assign addr_hi_zero = (paddr_i >> 8) == '0;
  assign gpr_sel = (addr_lo[7:5] == OAMU_GPR_PAGE) && (addr_lo[1:0] == 2'b00);
  assign gpr_idx = addr_lo[4:2];
  assign addr_ok = addr_hi_zero && (gpr_sel || addr_lo == OAMU_OFS_CTRL || addr_lo == OAMU_OFS_STATUS ||
                   addr_lo == OAMU_OFS_EADDR || addr_lo == OAMU_OFS_OPERAND || addr_lo == OAMU_OFS_PSW ||
                   addr_lo == OAMU_OFS_FLAGOP || addr_lo == OAMU_OFS_BRANCH ||
                   addr_lo == OAMU_OFS_ALU_A || addr_lo == OAMU_OFS_ALU);
  assign apb_wr = psel_i && penable_i && pwrite_i && addr_ok;
  assign apb_setup = psel_i && !penable_i;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_ok;
  assign prdata_o = prdata_r;
  assign mem_req_o = mem_r;
  assign busy_o = state_r != st_idle;
  assign flags_o = psw_r;

  assign start_field = oamu_field_t'(pwdata_i[5:0]);
  assign start_byte = pwdata_i[OAMU_CTRL_BYTE_BIT];
  assign start_req = apb_wr && addr_lo == OAMU_OFS_CTRL && pwdata_i[OAMU_CTRL_START_BIT] && state_r == st_idle;
  assign start_reg = gpr_r[start_field.rn];
  assign start_step = step_of(start_byte, start_field.rn);
  assign dec_val = start_reg - ((start_field.mode == mode_autodec) ? start_step : OAMU_STEP_WORD);
  assign pc_next = gpr_r[OAMU_PC_IDX] + OAMU_STEP_WORD;
  assign idx_sum = mem_rdata_i + ((field_r.rn == OAMU_PC_IDX) ? pc_next : gpr_r[field_r.rn]);

  assign br_off = pwdata_i[7:0];
  assign br_cond = oamu_cond_t'(pwdata_i[OAMU_BRANCH_COND_LSB +: 5]);
  assign br_target = gpr_r[OAMU_PC_IDX] + {{7{br_off[7]}}, br_off, 1'b0};

  assign alu_b = pwdata_i[15:0];
  assign alu_sub = pwdata_i[OAMU_ALU_SUB_BIT];
  assign alu_sum = alu_sub ? ({1'b0, alu_a_r} - {1'b0, alu_b}) : ({1'b0, alu_a_r} + {1'b0, alu_b});

  // Sequencer: general registers, memory requests and the formed address share one process.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < OAMU_NREG; i++)
      begin
        gpr_r[i] <= OAMU_GPR_RESET;
      end
      state_r <= st_idle;
      field_r <= oamu_field_t'(6'h00);
      byte_r <= 1'b0;
      done_r <= 1'b0;
      taken_r <= 1'b0;
      ea_r <= 16'h0000;
      opnd_r <= 16'h0000;
      mem_r <= '0;
    end
    else
    begin
      case (state_r)
        st_idle:
        begin
          // Software may only rewrite general registers while no operand is in flight.
          if (apb_wr && gpr_sel)
          begin
            gpr_r[gpr_idx] <= pwdata_i[15:0];
          end
          if (apb_wr && addr_lo == OAMU_OFS_BRANCH)
          begin
            taken_r <= cond_true(br_cond, psw_r);
            if (cond_true(br_cond, psw_r))
            begin
              gpr_r[OAMU_PC_IDX] <= br_target;
            end
          end
          if (start_req)
          begin
            field_r <= start_field;
            byte_r <= start_byte;
            done_r <= 1'b0;
            case (start_field.mode)
              mode_register:
              begin
                ea_r <= 16'h0000;
                opnd_r <= start_byte ? {8'h00, start_reg[7:0]} : start_reg;
                done_r <= 1'b1;
              end
              mode_reg_deferred:
              begin
                ea_r <= start_reg;
                done_r <= 1'b1;
              end
              mode_autoinc:
              begin
                if (start_field.rn == OAMU_PC_IDX)
                begin
                  mem_r <= '{req: 1'b1, addr: start_reg};
                  state_r <= st_xfetch;
                end
                else
                begin
                  ea_r <= start_reg;
                  gpr_r[start_field.rn] <= start_reg + start_step;
                  done_r <= 1'b1;
                end
              end
              mode_autoinc_deferred:
              begin
                mem_r <= '{req: 1'b1, addr: start_reg};
                state_r <= st_ptr;
              end
              mode_autodec:
              begin
                gpr_r[start_field.rn] <= dec_val;
                ea_r <= dec_val;
                done_r <= 1'b1;
              end
              mode_autodec_deferred:
              begin
                gpr_r[start_field.rn] <= dec_val;
                mem_r <= '{req: 1'b1, addr: dec_val};
                state_r <= st_ptr;
              end
              default:
              begin
                mem_r <= '{req: 1'b1, addr: gpr_r[OAMU_PC_IDX]};
                state_r <= st_xfetch;
              end
            endcase
          end
        end
        st_xfetch:
        begin
          if (mem_ack_i)
          begin
            gpr_r[OAMU_PC_IDX] <= pc_next;
            mem_r.req <= 1'b0;
            state_r <= st_idle;
            done_r <= 1'b1;
            if (field_r.mode == mode_autoinc)
            begin
              opnd_r <= mem_rdata_i;
              ea_r <= mem_r.addr;
            end
            else if (field_r.mode == mode_index)
            begin
              ea_r <= idx_sum;
            end
            else
            begin
              mem_r <= '{req: 1'b1, addr: idx_sum};
              state_r <= st_ptr;
              done_r <= 1'b0;
            end
          end
        end
        st_ptr:
        begin
          if (mem_ack_i)
          begin
            ea_r <= mem_rdata_i;
            mem_r.req <= 1'b0;
            state_r <= st_idle;
            done_r <= 1'b1;
            if (field_r.mode == mode_autoinc_deferred)
            begin
              gpr_r[field_r.rn] <= gpr_r[field_r.rn] + OAMU_STEP_WORD;
            end
          end
        end
        default:
        begin
          state_r <= st_idle;
          mem_r.req <= 1'b0;
        end
      endcase
    end
  end

  // Condition flags: direct write, flag set or clear, and arithmetic results.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      psw_r <= oamu_flags_t'(OAMU_PSW_RESET);
    end
    else if (apb_wr && addr_lo == OAMU_OFS_PSW)
    begin
      psw_r <= oamu_flags_t'(pwdata_i[3:0]);
    end
    else if (apb_wr && addr_lo == OAMU_OFS_FLAGOP)
    begin
      if (pwdata_i[OAMU_FLAGOP_SET_BIT])
      begin
        psw_r <= psw_r | oamu_flags_t'(pwdata_i[3:0]);
      end
      else
      begin
        psw_r <= psw_r & ~oamu_flags_t'(pwdata_i[3:0]);
      end
    end
    else if (apb_wr && addr_lo == OAMU_OFS_ALU)
    begin
      psw_r.c <= alu_sum[16];
      psw_r.n <= alu_sum[15];
      psw_r.z <= alu_sum[15:0] == 16'h0000;
      // Subtraction overflows when operand signs differ and the result takes the subtrahend's sign.
      psw_r.v <= alu_sub ? ((alu_a_r[15] != alu_b[15]) && (alu_sum[15] == alu_b[15]))
                         : ((alu_a_r[15] == alu_b[15]) && (alu_sum[15] != alu_a_r[15]));
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      alu_a_r <= 16'h0000;
      alu_res_r <= 16'h0000;
    end
    else
    begin
      if (apb_wr && addr_lo == OAMU_OFS_ALU_A)
      begin
        alu_a_r <= pwdata_i[15:0];
      end
      if (apb_wr && addr_lo == OAMU_OFS_ALU)
      begin
        alu_res_r <= alu_sum[15:0];
      end
    end
  end

  // Read data is captured in the setup cycle so the bus sees a flip-flop output.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      prdata_r <= 32'h0000_0000;
    end
    else if (apb_setup)
    begin
      prdata_r <= 32'h0000_0000;
      if (addr_hi_zero && gpr_sel)
      begin
        prdata_r <= {16'h0000, gpr_r[gpr_idx]};
      end
      else if (addr_hi_zero)
      begin
        case (addr_lo)
          OAMU_OFS_CTRL: prdata_r <= {25'h000_0000, byte_r, field_r};
          OAMU_OFS_STATUS: prdata_r <= {30'h0000_0000, done_r, busy_o};
          OAMU_OFS_EADDR: prdata_r <= {16'h0000, ea_r};
          OAMU_OFS_OPERAND: prdata_r <= {16'h0000, opnd_r};
          OAMU_OFS_PSW: prdata_r <= {28'h000_0000, psw_r};
          OAMU_OFS_BRANCH: prdata_r <= {15'h0000, taken_r, 16'h0000};
          OAMU_OFS_ALU_A: prdata_r <= {16'h0000, alu_a_r};
          OAMU_OFS_ALU: prdata_r <= {16'h0000, alu_res_r};
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ---- tb/oamu_mem_model.sv ----
// Purpose: Memory port model that answers operand and pointer reads.
// Assumes: Same clock as the unit, one read outstanding at a time.
// Notes: Each word read back is the inverse of its address.
`timescale 1ns/1ps
module oamu_mem_model
  import oamu_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire oamu_mem_req_t mem_req_i,
  input wire logic [3:0] lat_i,
  output logic mem_ack_o,
  output logic [15:0] mem_rdata_o
);
  logic [3:0] cnt_r;
  logic [15:0] word_r;
  // Outside an ack the data lines flip, so a stale sample never matches.
  assign mem_rdata_o = mem_ack_o ? word_r : ~word_r;
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= 4'h0;
      mem_ack_o <= 1'b0;
      word_r <= 16'h0000;
    end
    else
    begin
      mem_ack_o <= 1'b0;
      if (mem_req_i.req && !mem_ack_o)
      begin
        if (cnt_r >= lat_i)
        begin
          mem_ack_o <= 1'b1;
          word_r <= ~mem_req_i.addr;
          cnt_r <= 4'h0;
        end
        else
          cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule

// ---- tb/oamu_core_sva.sv ----
// Purpose: Port checks for the operand address mode unit.
// Assumes: One clock, synchronous active-low reset.
// Notes: Effective addresses and branch targets are checked by the bench.
`timescale 1ns/1ps
module oamu_core_sva
  import oamu_pkg::*;
#(
  parameter int APB_AW = 8
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire oamu_mem_req_t mem_req_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  input wire logic busy_o,
  input wire oamu_flags_t flags_o
);
  logic acc_w;
  logic start_w;
  logic fetch_w;
  logic [2:0] md;
  assign acc_w = psel_i && penable_i && pwrite_i;
  assign md = pwdata_i[5:3];
  assign start_w = acc_w && paddr_i == APB_AW'(OAMU_OFS_CTRL) && pwdata_i[OAMU_CTRL_START_BIT] && !busy_o;
  assign fetch_w = md == 3'h3 || md == 3'h5 || md >= 3'h6 || (md == 3'h2 && pwdata_i[2:0] == OAMU_PC_IDX);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_req_hold:
  assert property (mem_req_o.req && !mem_ack_i |=> mem_req_o.req && $stable(mem_req_o.addr))
    else $error("memory request changed before ack");
  chk_req_busy:
  assert property (mem_req_o.req |-> busy_o)
    else $error("memory request while idle");
  chk_ack_release:
  assert property (mem_ack_i && mem_req_o.req |=> !mem_req_o.req || mem_req_o.addr != $past(mem_req_o.addr))
    else $error("request not released after ack");
  chk_fast_mode:
  assert property (start_w && !fetch_w |=> !busy_o && !mem_req_o.req)
    else $error("register mode started a fetch");
  chk_fetch_start:
  assert property (start_w && fetch_w |=> busy_o && mem_req_o.req)
    else $error("fetch mode did not request memory");
  chk_flag_op:
  assert property (acc_w && paddr_i == APB_AW'(OAMU_OFS_FLAGOP) |=> flags_o == ($past(pwdata_i[4]) ?
    ($past(flags_o) | $past(pwdata_i[3:0])) : ($past(flags_o) & ~$past(pwdata_i[3:0]))))
    else $error("flag set or clear wrong");
  chk_psw_load:
  assert property (acc_w && paddr_i == APB_AW'(OAMU_OFS_PSW) |=> flags_o == $past(pwdata_i[3:0]))
    else $error("status word load wrong");
  chk_word_read:
  assert property (psel_i && penable_i |-> prdata_o[31:17] == 15'h0000)
    else $error("upper read bits not zero");
endmodule
bind oamu_core oamu_core_sva #(.APB_AW(APB_AW)) u_sva (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_req_o(mem_req_o),
  .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .flags_o(flags_o));

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the operand address mode unit.
// Assumes: APB master on the 10 MHz clock, memory model on the far side.
// Notes: Memory latency changes per row so fetches stall by varying amounts.
`timescale 1ns/1ps
module tb_top;
  import oamu_pkg::*;
  typedef struct {logic [2:0] md, rn; logic bt; logic [15:0] init, ea, rv, pc, op;} oamu_row_t;
  typedef struct {logic [3:0] psw; logic [4:0] cond; logic [7:0] off; logic tk;} oamu_br_t;
  logic clk, rst_n, psel, pen, pwr, pready, perr, busy, ack, qe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] rdata;
  logic [3:0] lat;
  oamu_mem_req_t mreq;
  oamu_flags_t flags;
  int error_cnt = 0;
  int total_checks = 0;
  oamu_row_t rows [17] = '{'{3'h0, 3'h2, 1'b0, 16'h1234, 16'h0000, 16'h1234, 16'h0200, 16'h1234},
    '{3'h0, 3'h2, 1'b1, 16'h1234, 16'h0000, 16'h1234, 16'h0200, 16'h0034},
    '{3'h1, 3'h3, 1'b0, 16'h0300, 16'h0300, 16'h0300, 16'h0200, 16'h0000},
    '{3'h2, 3'h1, 1'b0, 16'h0400, 16'h0400, 16'h0402, 16'h0200, 16'h0000},
    '{3'h2, 3'h1, 1'b1, 16'h0400, 16'h0400, 16'h0401, 16'h0200, 16'h0000},
    '{3'h2, 3'h6, 1'b1, 16'h0400, 16'h0400, 16'h0402, 16'h0200, 16'h0000},
    '{3'h2, 3'h7, 1'b1, 16'h0200, 16'h0200, 16'h0202, 16'h0202, 16'hFDFF},
    '{3'h3, 3'h4, 1'b0, 16'h0500, 16'hFAFF, 16'h0502, 16'h0200, 16'h0000},
    '{3'h3, 3'h7, 1'b0, 16'h0200, 16'hFDFF, 16'h0202, 16'h0202, 16'h0000},
    '{3'h4, 3'h5, 1'b0, 16'h0600, 16'h05FE, 16'h05FE, 16'h0200, 16'h0000},
    '{3'h4, 3'h5, 1'b1, 16'h0600, 16'h05FF, 16'h05FF, 16'h0200, 16'h0000},
    '{3'h4, 3'h6, 1'b1, 16'h0600, 16'h05FE, 16'h05FE, 16'h0200, 16'h0000},
    '{3'h5, 3'h2, 1'b0, 16'h0700, 16'hF901, 16'h06FE, 16'h0200, 16'h0000},
    '{3'h6, 3'h3, 1'b0, 16'h0800, 16'h05FF, 16'h0800, 16'h0202, 16'h0000},
    '{3'h6, 3'h7, 1'b0, 16'h0200, 16'h0001, 16'h0202, 16'h0202, 16'h0000},
    '{3'h7, 3'h3, 1'b0, 16'h0800, 16'hFA00, 16'h0800, 16'h0202, 16'h0000},
    '{3'h7, 3'h7, 1'b0, 16'h0200, 16'hFFFE, 16'h0202, 16'h0202, 16'h0000}};
  oamu_br_t brs [18] = '{'{4'h0, 5'h00, 8'h80, 1'b1}, '{4'h4, 5'h01, 8'h01, 1'b0}, '{4'h4, 5'h02, 8'h7F, 1'b1},
    '{4'h8, 5'h03, 8'h01, 1'b0}, '{4'h8, 5'h04, 8'h01, 1'b1}, '{4'h0, 5'h05, 8'h01, 1'b1},
    '{4'h0, 5'h06, 8'h01, 1'b0}, '{4'h8, 5'h07, 8'h01, 1'b0}, '{4'h8, 5'h08, 8'h01, 1'b1},
    '{4'h1, 5'h09, 8'h01, 1'b0}, '{4'h1, 5'h0A, 8'h01, 1'b1}, '{4'h2, 5'h0B, 8'h01, 1'b0},
    '{4'h2, 5'h0C, 8'h01, 1'b1}, '{4'h1, 5'h0D, 8'h01, 1'b0}, '{4'h1, 5'h0E, 8'h01, 1'b1},
    '{4'h0, 5'h0F, 8'h01, 1'b1}, '{4'h0, 5'h10, 8'h01, 1'b0}, '{4'hF, 5'h11, 8'h01, 1'b0}};
  oamu_core DUT (.sys_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .mem_req_o(mreq), .mem_ack_i(ack), .mem_rdata_i(rdata), .busy_o(busy), .flags_o(flags));
  oamu_mem_model u_mem (.sys_clk_i(clk), .rst_n_i(rst_n), .mem_req_i(mreq), .lat_i(lat), .mem_ack_o(ack),
    .mem_rdata_o(rdata));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    q = prdata;
    qe = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 16)
    begin
      error_cnt++;
      summarize();
    end
  endtask
  task wait_done();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, OAMU_OFS_STATUS, 32'h0000_0000);
      n++;
    end
    while (q[OAMU_STATUS_DONE_BIT] !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      error_cnt++;
      summarize();
    end
  endtask
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    lat = 4'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      lat <= 4'(i % 4);
      apb(1'b1, 8'h5C, 32'h0000_0200);
      apb(1'b1, {OAMU_GPR_PAGE, rows[i].rn, 2'b00}, {16'h0000, rows[i].init});
      apb(1'b1, OAMU_OFS_CTRL, {23'h00_0000, 1'b1, 1'b0, rows[i].bt, rows[i].md, rows[i].rn});
      wait_done();
      apb(1'b0, OAMU_OFS_EADDR, 32'h0000_0000);
      chk(q, {16'h0000, rows[i].ea}, "effective address");
      apb(1'b0, {OAMU_GPR_PAGE, rows[i].rn, 2'b00}, 32'h0000_0000);
      chk(q, {16'h0000, rows[i].rv}, "register after");
      apb(1'b0, 8'h5C, 32'h0000_0000);
      chk(q, {16'h0000, rows[i].pc}, "program counter");
      apb(1'b0, OAMU_OFS_CTRL, 32'h0000_0000);
      chk({25'h000_0000, q[6:0]}, {25'h000_0000, rows[i].bt, rows[i].md, rows[i].rn}, "field");
      if (rows[i].md == 3'h0 || (rows[i].md == 3'h2 && rows[i].rn == 3'h7))
      begin
        apb(1'b0, OAMU_OFS_OPERAND, 32'h0000_0000);
        chk(q, {16'h0000, rows[i].op}, "operand");
      end
    end
    foreach (brs[i])
    begin
      apb(1'b1, OAMU_OFS_PSW, {28'h000_0000, brs[i].psw});
      apb(1'b1, 8'h5C, 32'h0000_1000);
      apb(1'b1, OAMU_OFS_BRANCH, {19'h0_0000, brs[i].cond, brs[i].off});
      apb(1'b0, OAMU_OFS_BRANCH, 32'h0000_0000);
      chk({31'h0000_0000, q[16]}, {31'h0000_0000, brs[i].tk}, "branch taken");
      apb(1'b0, 8'h5C, 32'h0000_0000);
      chk(q, {16'h0000, 16'h1000 + (brs[i].tk ? {{7{brs[i].off[7]}}, brs[i].off, 1'b0} : 16'h0000)}, "target");
    end
    apb(1'b1, OAMU_OFS_FLAGOP, 32'h0000_000F);
    for (int b = 0; b < 4; b++)
    begin
      apb(1'b1, OAMU_OFS_FLAGOP, 32'h0000_0010 | (1 << b));
      apb(1'b0, OAMU_OFS_PSW, 32'h0000_0000);
      chk(q, 1 << b, "single set");
      apb(1'b1, OAMU_OFS_FLAGOP, 1 << b);
      apb(1'b0, OAMU_OFS_PSW, 32'h0000_0000);
      chk(q, 32'h0000_0000, "single clear");
    end
    apb(1'b1, OAMU_OFS_ALU_A, 32'h0000_7FFF);
    apb(1'b1, OAMU_OFS_ALU, 32'h0000_0001);
    apb(1'b0, OAMU_OFS_PSW, 32'h0000_0000);
    chk(q, 32'h0000_000A, "signed overflow");
    apb(1'b1, OAMU_OFS_ALU_A, 32'h0000_FFFF);
    apb(1'b1, OAMU_OFS_ALU, 32'h0000_0001);
    apb(1'b0, OAMU_OFS_PSW, 32'h0000_0000);
    chk(q, 32'h0000_0005, "carry and zero");
    apb(1'b1, OAMU_OFS_ALU_A, 32'h0000_0000);
    apb(1'b1, OAMU_OFS_ALU, 32'h0001_0001);
    apb(1'b0, OAMU_OFS_ALU, 32'h0000_0000);
    chk(q, 32'h0000_FFFF, "difference");
    apb(1'b0, OAMU_OFS_PSW, 32'h0000_0000);
    chk(q, 32'h0000_0009, "borrow and minus");
    lat <= 4'h8;
    apb(1'b1, 8'h4C, 32'h0000_0800);
    apb(1'b1, 8'h5C, 32'h0000_0200);
    apb(1'b1, OAMU_OFS_CTRL, 32'h0000_0133);
    apb(1'b1, 8'h4C, 32'h0000_FFFF);
    apb(1'b1, OAMU_OFS_CTRL, 32'h0000_0102);
    wait_done();
    apb(1'b0, OAMU_OFS_EADDR, 32'h0000_0000);
    chk(q, 32'h0000_05FF, "address after busy start");
    apb(1'b0, 8'h4C, 32'h0000_0000);
    chk(q, 32'h0000_0800, "register write while busy");
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk({31'h0000_0000, qe}, 32'h0000_0001, "unmapped error");
    chk(q, 32'h0000_0000, "unmapped data");
    apb(1'b1, OAMU_OFS_FLAGOP, 32'h0000_001F);
    apb(1'b0, OAMU_OFS_PSW, 32'h0000_0000);
    chk(q, 32'h0000_000F, "set all");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, OAMU_OFS_PSW, 32'h0000_0000);
    chk(q, 32'h0000_0000, "flags after reset");
    apb(1'b0, 8'h4C, 32'h0000_0000);
    chk({28'h000_0000, flags}, 32'h0000_0000, "flag port after reset");
    chk(q, 32'h0000_0000, "register after reset");
    summarize();
  end
endmodule
